// ### hw/prom_readout_pkg.sv
package prom_readout_pkg;
    // ****************************************
    // storage geometry
    // ****************************************
    localparam int BLOCK_AW = 20;
    localparam int ADDR_W = 23;
    localparam int MEM_AW = 22;
    localparam logic [22:0] BLOCK_BYTES = 23'h100000;
    localparam logic [22:0] BLOCK_MASK = 23'h0fffff;
    localparam logic [2:0] NUM_BLOCKS = 3'h4;
    localparam logic [23:0] STORE_CAP = 24'h400000;
    localparam logic [7:0] PAD_BYTE = 8'hff;
    // ****************************************
    // revision codes
    // ****************************************
    localparam logic [1:0] REV_0 = 2'h0;
    localparam logic [1:0] REV_1 = 2'h1;
    localparam logic [1:0] REV_2 = 2'h2;
    localparam logic [1:0] REV_3 = 2'h3;
    localparam logic [1:0] REV_MASK = 2'(NUM_BLOCKS - 3'h1);
    // ****************************************
    // buffering and serial framing
    // ****************************************
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] LAST_BIT = 3'h7;
    // ****************************************
    // readout state
    // ****************************************
    typedef struct packed {
        logic clk_prev;
        logic pulse_prev;
        logic sample_pend;
        logic [1:0] rev;
        logic [22:0] faddr;
        logic [22:0] fend;
        logic [22:0] fused;
        logic fetching;
        logic [7:0] shreg;
        logic shreg_vld;
        logic [2:0] bit_idx;
        logic done;
        logic [7:0] dout;
        logic src_clk;
    } readout_state_type;
endpackage

// ### hw/config_prom_revision_readout.sv
`timescale 1ns/1ps

// ****************************************
// byte buffer between fetch and output
// ****************************************
module readout_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_state_type;
    fifo_state_type q, d;
    logic push, pop;

    assign in_ready_out = q.cnt != (AW+1)'(DEPTH);
    assign out_valid_out = q.cnt != '0;
    assign out_data_out = q.mem[q.rd];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_comb begin
        d = q;
        if (flush_in) begin
            d.wr = '0;
            d.rd = '0;
            d.cnt = '0;
        end else begin
            if (push) begin
                d.mem[q.wr] = in_data_in;
                d.wr = q.wr + 1'b1;
            end
            if (pop) begin
                d.rd = q.rd + 1'b1;
            end
            d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// Summary of operation
// - revisions whole blocks, unused tail reads ones
// - four revisions coded by two bits
// - revision count limited by block capacity
// - revision continues into next chained memory
// - selection works with source clock
// - external enable low: select from pins
// - external enable high: select from internal bits
// - selection sampled at power-up and again whenever output-enable/reset is low
// - chip enabled: resample after pulse rising edge
// - serial bit out per clock edge, address advances per byte fetched
// - new bit presented well before next edge
// - slave serial: source clock or external clock
// - cascade enable drives next chip enable
// - output-enable/reset resets address counter
// - chip enable held low keeps data driven until memory finished
// - pulse pin used as input only, its output driver never enabled
// - serial modes plus byte-wide parallel readout
// - finished memory stops clock, releases cascade
module config_prom_revision_readout (
    input wire logic sys_clk_in,
    input wire logic srst_in,
    input wire logic config_clock_in,
    input wire logic chip_enable_n_in,
    input wire logic oe_reset_n_in,
    input wire logic config_pulse_in,
    output logic config_pulse_out,
    output logic config_pulse_oe_n_out,
    input wire logic external_select_enable_in,
    input wire logic [1:0] revision_select_pins_in,
    input wire logic [1:0] internal_revision_bits_in,
    input wire logic [3:0][1:0] rev_first_block_in,
    input wire logic [3:0][22:0] rev_used_bytes_in,
    input wire logic parallel_mode_in,
    input wire logic source_clock_enable_in,
    output logic [prom_readout_pkg::MEM_AW-1:0] mem_addr_out,
    input wire logic [7:0] mem_data_in,
    output logic [7:0] data_out,
    output logic data_oe_n_out,
    output logic source_clock_out,
    output logic source_clock_oe_n_out,
    output logic cascade_enable_n_out
);
    import prom_readout_pkg::*;

    // ****************************************
    // revision address helpers
    // ****************************************
    function automatic logic [22:0] rev_start(input logic [1:0] first);
        rev_start = {1'b0, first, 20'h00000};
    endfunction

    function automatic logic [22:0] rev_end(input logic [1:0] first, input logic [22:0] used);
        logic [22:0] span;
        logic [23:0] sum;
        span = (used + BLOCK_MASK) & ~BLOCK_MASK;
        if (used == '0) begin
            span = BLOCK_BYTES;
        end
        sum = {1'b0, rev_start(first)} + {1'b0, span};
        rev_end = (sum > STORE_CAP) ? STORE_CAP[22:0] : sum[22:0];
    endfunction

    readout_state_type q, d;
    logic rise, pulse_rise, active, restart, fifo_flush;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic [7:0] fifo_in_data, fifo_out_data;
    logic [1:0] new_rev;

    // ****************************************
    // pin decode
    // ****************************************
    assign rise = config_clock_in && !q.clk_prev;
    assign pulse_rise = config_pulse_in && !q.pulse_prev;
    assign active = !chip_enable_n_in && oe_reset_n_in && !q.done;
    assign new_rev = (external_select_enable_in ? internal_revision_bits_in
                      : revision_select_pins_in) & REV_MASK;
    assign restart = q.sample_pend || !oe_reset_n_in
                     || (pulse_rise && !chip_enable_n_in);
    assign fifo_flush = restart;
    assign fifo_in_valid = q.fetching && !restart;
    assign fifo_in_data = (q.faddr < q.fused) ? mem_data_in : PAD_BYTE;
    assign fifo_out_ready = !q.shreg_vld && !restart;

    readout_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .flush_in(fifo_flush),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.clk_prev = config_clock_in;
        d.pulse_prev = config_pulse_in;
        if (restart) begin
            d.sample_pend = 1'b0;
            d.rev = new_rev;
            d.faddr = rev_start(rev_first_block_in[new_rev]);
            d.fused = rev_start(rev_first_block_in[new_rev]) + rev_used_bytes_in[new_rev];
            d.fend = rev_end(rev_first_block_in[new_rev], rev_used_bytes_in[new_rev]);
            d.fetching = 1'b1;
            d.shreg_vld = 1'b0;
            d.bit_idx = '0;
            d.done = 1'b0;
        end else begin
            if (fifo_in_valid && fifo_in_ready) begin
                d.faddr = q.faddr + 23'h1;
                if (d.faddr == q.fend) begin
                    d.fetching = 1'b0;
                end
            end
            if (rise && active && q.shreg_vld) begin
                if (parallel_mode_in || q.bit_idx == LAST_BIT) begin
                    d.shreg_vld = 1'b0;
                end else begin
                    d.bit_idx = q.bit_idx + 3'h1;
                end
            end
            if (fifo_out_ready && fifo_out_valid) begin
                d.shreg = fifo_out_data;
                d.shreg_vld = 1'b1;
                d.bit_idx = '0;
            end
            if (!q.fetching && !fifo_out_valid && !q.shreg_vld) begin
                d.done = 1'b1;
            end
        end
        if (d.shreg_vld) begin
            d.dout = parallel_mode_in ? d.shreg
                     : {7'h00, d.shreg[LAST_BIT - d.bit_idx]};
        end
        d.src_clk = source_clock_enable_in && active && config_clock_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            q <= '0;
            q.sample_pend <= 1'b1;
            q.pulse_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign mem_addr_out = q.faddr[MEM_AW-1:0];
    assign data_out = q.dout;
    assign data_oe_n_out = !active;
    assign source_clock_out = q.src_clk;
    assign source_clock_oe_n_out = !(source_clock_enable_in && active);
    assign cascade_enable_n_out = !q.done;
    assign config_pulse_out = 1'b1;
    assign config_pulse_oe_n_out = 1'b1;

    // ****************************************
    // checks
    // ****************************************
    property p_pins_sel;
        @(posedge sys_clk_in) disable iff (srst_in)
        q.sample_pend && !external_select_enable_in |=> q.rev == $past(revision_select_pins_in);
    endproperty
    a_pins_sel: assert property (p_pins_sel) else $error("pin select not taken");

    property p_int_sel;
        @(posedge sys_clk_in) disable iff (srst_in)
        q.sample_pend && external_select_enable_in
        |=> q.rev == $past(internal_revision_bits_in);
    endproperty
    a_int_sel: assert property (p_int_sel) else $error("internal select not taken");

    property p_once;
        @(posedge sys_clk_in) disable iff (srst_in)
        q.sample_pend |=> !q.sample_pend [*2];
    endproperty
    a_once: assert property (p_once) else $error("power-up sample repeated");

    property p_resample;
        @(posedge sys_clk_in) disable iff (srst_in)
        pulse_rise && !chip_enable_n_in
        |=> q.faddr == rev_start(rev_first_block_in[q.rev]) && q.fetching;
    endproperty
    a_resample: assert property (p_resample) else $error("pulse did not restart");

    property p_pulse_refused;
        @(posedge sys_clk_in) disable iff (srst_in)
        pulse_rise && chip_enable_n_in && oe_reset_n_in && !q.sample_pend
        |=> q.rev == $past(q.rev);
    endproperty
    a_pulse_refused: assert property (p_pulse_refused) else $error("pulse taken while disabled");

    property p_reset_addr;
        @(posedge sys_clk_in) disable iff (srst_in)
        !oe_reset_n_in |=> !q.shreg_vld && q.faddr == rev_start(rev_first_block_in[q.rev]);
    endproperty
    a_reset_addr: assert property (p_reset_addr) else $error("counter not reset");

    property p_pad;
        @(posedge sys_clk_in) disable iff (srst_in)
        fifo_in_valid && q.faddr >= q.fused |-> fifo_in_data == PAD_BYTE;
    endproperty
    a_pad: assert property (p_pad) else $error("padding not all ones");

    property p_bit_step;
        @(posedge sys_clk_in) disable iff (srst_in)
        rise && active && q.shreg_vld && !parallel_mode_in && q.bit_idx != LAST_BIT && !restart
        |=> q.bit_idx == $past(q.bit_idx) + 3'h1;
    endproperty
    a_bit_step: assert property (p_bit_step) else $error("bit index did not advance");

    property p_rev_cap;
        @(posedge sys_clk_in) disable iff (srst_in)
        !q.sample_pend |-> {1'b0, q.rev} < NUM_BLOCKS;
    endproperty
    a_rev_cap: assert property (p_rev_cap) else $error("revision beyond capacity");

    property p_handoff;
        @(posedge sys_clk_in) disable iff (srst_in)
        q.done |-> !cascade_enable_n_out && data_oe_n_out && source_clock_oe_n_out ##1 !q.src_clk;
    endproperty
    a_handoff: assert property (p_handoff) else $error("finished memory did not hand off");

    property p_drive;
        @(posedge sys_clk_in) disable iff (srst_in)
        !chip_enable_n_in && oe_reset_n_in && !q.done |-> !data_oe_n_out;
    endproperty
    a_drive: assert property (p_drive) else $error("data not driven");
endmodule

// ### tb/fpga_cfg_model.sv
`timescale 1ns/1ps

// ****************************************
// fpga side of the configuration link
// ****************************************
module fpga_cfg_model (
    input wire logic sys_clk_in,
    input wire logic [7:0] data_in,
    input wire logic parallel_in,
    output logic config_clock_out,
    output logic chip_enable_n_out,
    output logic oe_reset_n_out,
    output logic config_pulse_out
);
    initial begin
        config_clock_out = 1'b0;
        chip_enable_n_out = 1'b0;
        oe_reset_n_out = 1'b1;
        config_pulse_out = 1'b1;
    end
    // ****************************************
    // one byte: eight clocks serial, one parallel
    // ****************************************
    task automatic take_byte(output logic [7:0] b);
        int n;
        n = parallel_in ? 1 : 8;
        b = 8'h00;
        for (int i = 0; i < n; i++) begin
            repeat (8) @(posedge sys_clk_in);
            #1;
            config_clock_out = 1'b1;
            b = parallel_in ? data_in : {b[6:0], data_in[0]};
            repeat (4) @(posedge sys_clk_in);
            #1;
            config_clock_out = 1'b0;
        end
    endtask
    // ****************************************
    // control lines
    // ****************************************
    task automatic set_ce(input logic v);
        @(posedge sys_clk_in);
        #1;
        chip_enable_n_out = v;
    endtask
    task automatic pulse_cf();
        @(posedge sys_clk_in);
        #1;
        config_pulse_out = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        config_pulse_out = 1'b1;
        repeat (2) @(posedge sys_clk_in);
    endtask
    task automatic restart_oe();
        @(posedge sys_clk_in);
        #1;
        oe_reset_n_out = 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        oe_reset_n_out = 1'b1;
    endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps

// ****************************************
// top bench
// ****************************************
module tb_top;
    import prom_readout_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic ccl, ce_n, oer_n, fpga_cf, cf_out, cf_oe_n;
    logic ext_en = 1'b0;
    logic par = 1'b0;
    logic sce = 1'b1;
    logic [1:0] pins = 2'h2;
    logic [1:0] ibits = 2'h3;
    logic [3:0][1:0] first_blk = {2'h0, 2'h1, 2'h2, 2'h3};
    logic [3:0][22:0] used = {23'h100000, 23'h100000, 23'h000002, 23'h100000};
    logic [MEM_AW-1:0] maddr;
    logic [7:0] dout, b, mdata;
    logic doe_n, sclk, sclk_oe_n, cas_n;
    wire cf_wire = fpga_cf & (cf_oe_n | cf_out);
    int n_fail = 0;
    int cmp_count = 0;
    always #5 sys_clk = ~sys_clk;
    assign mdata = mem(maddr);
    fpga_cfg_model fpga (.sys_clk_in(sys_clk), .data_in(doe_n ? ~dout : dout), .parallel_in(par),
        .config_clock_out(ccl), .chip_enable_n_out(ce_n), .oe_reset_n_out(oer_n),
        .config_pulse_out(fpga_cf));
    config_prom_revision_readout dut (.sys_clk_in(sys_clk), .srst_in(srst),
        .config_clock_in(ccl), .chip_enable_n_in(ce_n), .oe_reset_n_in(oer_n),
        .config_pulse_in(cf_wire), .config_pulse_out(cf_out), .config_pulse_oe_n_out(cf_oe_n),
        .external_select_enable_in(ext_en), .revision_select_pins_in(pins),
        .internal_revision_bits_in(ibits), .rev_first_block_in(first_blk),
        .rev_used_bytes_in(used), .parallel_mode_in(par), .source_clock_enable_in(sce),
        .mem_addr_out(maddr), .mem_data_in(mdata), .data_out(dout), .data_oe_n_out(doe_n),
        .source_clock_out(sclk), .source_clock_oe_n_out(sclk_oe_n),
        .cascade_enable_n_out(cas_n));
    // ****************************************
    // storage pattern and checks
    // ****************************************
    function automatic logic [7:0] mem(input logic [21:0] a);
        return a[7:0] ^ {a[21:20], 6'h15};
    endfunction
    function automatic logic [21:0] base(input int r);
        return {2'(3 - r), 20'h00000};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input string nm, input logic [7:0] e);
        fpga.take_byte(b);
        chk(nm, e, b);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_powerup();
        fork
            rd("pin rev byte0", mem(base(2)));
            begin
                repeat (10) @(posedge sys_clk);
                #1;
                chk("srcclk high", 8'h01, {7'h0, sclk});
                repeat (4) @(posedge sys_clk);
                #1;
                chk("srcclk low", 8'h00, {7'h0, sclk});
            end
        join
        chk("data oe_n", 8'h00, {7'h0, doe_n});
        chk("srcclk oe_n", 8'h00, {7'h0, sclk_oe_n});
        chk("cascade_n", 8'h01, {7'h0, cas_n});
        chk("cf oe_n", 8'h01, {7'h0, cf_oe_n});
        $display("test powerup done");
    endtask
    task automatic t_internal();
        @(posedge sys_clk);
        #1;
        ext_en = 1'b1;
        pins = 2'h0;
        fpga.pulse_cf();
        rd("internal rev byte0", mem(base(3)));
        $display("test internal done");
    endtask
    task automatic t_ce_high();
        @(posedge sys_clk);
        #1;
        ext_en = 1'b0;
        pins = 2'h1;
        fpga.set_ce(1'b1);
        repeat (2) @(posedge sys_clk);
        #1;
        chk("data oe_n ce high", 8'h01, {7'h0, doe_n});
        fpga.pulse_cf();
        fpga.set_ce(1'b0);
        rd("no resample", mem(base(3) + 22'h1));
        $display("test ce_high done");
    endtask
    task automatic t_pad_restart();
        fpga.pulse_cf();
        rd("rev1 byte0", mem(base(1)));
        rd("rev1 byte1", mem(base(1) + 22'h1));
        rd("rev1 pad", PAD_BYTE);
        rd("rev1 pad again", PAD_BYTE);
        fpga.restart_oe();
        rd("restart byte0", mem(base(1)));
        $display("test pad_restart done");
    endtask
    task automatic t_parallel();
        par = 1'b1;
        for (int r = 0; r < 4; r++) begin
            @(posedge sys_clk);
            #1;
            pins = 2'(r);
            fpga.pulse_cf();
            rd("par byte0", mem(base(r)));
            rd("par byte1", mem(base(r) + 22'h1));
        end
        $display("test parallel done");
    endtask
    task automatic t_mid_reset();
        @(posedge sys_clk);
        #1;
        srst = 1'b1;
        ext_en = 1'b1;
        par = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        rd("reset internal byte0", mem(base(3)));
        chk("cascade_n after reset", 8'h01, {7'h0, cas_n});
        sce = 1'b0;
        @(posedge sys_clk);
        #1;
        chk("srcclk oe_n off", 8'h01, {7'h0, sclk_oe_n});
        $display("test mid_reset done");
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        t_powerup();
        t_internal();
        t_ce_high();
        t_pad_restart();
        t_parallel();
        t_mid_reset();
        print_verdict();
    end
endmodule
